// ### hdl/see_eeprom_slave.sv
// Two-wire serial slave access logic of a 128 x 8 EEPROM.
`include "see_eeprom_map.svh"

module see_eeprom_slave #(
   // Device type code; the value is arbitrary.
   parameter logic [3:0]  P_TYPE_ID   = 4'h5,
   parameter int unsigned P_WR_CYCLES = `SEE_T_WR_NS / `SEE_MCLK_NS
) (
   input  wire logic i_mclk,
   input  wire logic i_reset,
   input  wire logic i_scl,
   input  wire logic i_sda_in,
   input  wire logic i_write_protect_input,
   output logic      o_sda_out,
   output logic      o_sda_oe_n,
   output logic      o_busy
);

   logic                      scl_f;
   logic                      sda_f;
   logic                      wp_f;
   logic                      scl_prev_q;
   logic                      sda_prev_q;
   logic                      scl_rise;
   logic                      scl_fall;
   logic                      ev_start;
   logic                      ev_stop;
   see_pkg::see_state_t       state_q;
   see_pkg::see_state_t       next_q;
   logic [3:0]                cnt_q;
   logic [7:0]                sh_q;
   logic                      mack_q;
   logic [`SEE_ADDR_W-1:0]    addr_q;
   logic [7:0]                pbuf_q [`SEE_PAGE_BYTES];
   logic [`SEE_PAGE_BYTES-1:0] pmask_q;
   logic                      busy_q;
   logic [`SEE_WR_CNT_W-1:0]  wr_cnt_q;
   logic [7:0]                mem_q [`SEE_MEM_DEPTH];
   logic                      rx_state;
   logic                      byte_end;
   logic                      sel_ok;
   logic                      ld_rd;
   logic                      wr_byte;
   logic                      wr_take;
   logic                      addr_load;
   logic                      commit;
   logic [7:0]                rd_byte;
   logic [`SEE_ROW_W-1:0]     row;

   // Every pin from the bus passes the same filtered synchroniser.
   see_pin_sync #(
      .P_RESET_LEVEL (`SEE_BUS_IDLE)
   ) u_scl_sync (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_pin   (i_scl),
      .o_level (scl_f)
   );

   see_pin_sync #(
      .P_RESET_LEVEL (`SEE_BUS_IDLE)
   ) u_sda_sync (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_pin   (i_sda_in),
      .o_level (sda_f)
   );

   see_pin_sync #(
      .P_RESET_LEVEL (`SEE_BUS_IDLE)
   ) u_wp_sync (
      .i_mclk  (i_mclk),
      .i_reset (i_reset),
      .i_pin   (i_write_protect_input),
      .o_level (wp_f)
   );

   // Previous filtered levels, for edge and condition detection.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         scl_prev_q <= `SEE_BUS_IDLE;
         sda_prev_q <= `SEE_BUS_IDLE;
      end else begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   assign scl_rise = scl_f & ~scl_prev_q;
   assign scl_fall = ~scl_f & scl_prev_q;
   // A data edge with the clock held high is a bus condition, not a bit.
   assign ev_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign ev_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   assign rx_state = (state_q == see_pkg::SEE_ST_SEL)
                   | (state_q == see_pkg::SEE_ST_ADDR)
                   | (state_q == see_pkg::SEE_ST_WDAT);
   // The byte is closed on the falling clock after its eighth bit.
   assign byte_end = scl_fall & rx_state & (cnt_q == `SEE_BYTE_BITS);
   assign sel_ok   = (sh_q[`SEE_SEL_TYPE_HI:`SEE_SEL_TYPE_LO] == P_TYPE_ID)
                   & ~busy_q;
   assign ld_rd    = scl_fall
                   & (((state_q == see_pkg::SEE_ST_ACK)
                       & (next_q == see_pkg::SEE_ST_RDAT))
                      | ((state_q == see_pkg::SEE_ST_MACK) & mack_q));
   assign wr_byte  = byte_end & (state_q == see_pkg::SEE_ST_WDAT);
   assign wr_take  = wr_byte & wp_f;
   assign addr_load = byte_end & (state_q == see_pkg::SEE_ST_ADDR);
   assign commit   = ev_stop & (pmask_q != '0) & ~busy_q;
   assign rd_byte  = mem_q[addr_q];
   assign row      = addr_q[`SEE_ADDR_W-1:`SEE_PAGE_W];

   // Bus protocol engine: bit counting, acknowledge and data drive.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         state_q    <= see_pkg::SEE_ST_IDLE;
         next_q     <= see_pkg::SEE_ST_IDLE;
         cnt_q      <= 4'h0;
         sh_q       <= 8'h00;
         mack_q     <= 1'b0;
         o_sda_oe_n <= 1'b1;
      end else if (ev_start) begin
         // A repeated start is taken in any state, even mid-byte.
         state_q    <= see_pkg::SEE_ST_SEL;
         cnt_q      <= 4'h0;
         o_sda_oe_n <= 1'b1;
      end else if (ev_stop) begin
         state_q    <= see_pkg::SEE_ST_IDLE;
         cnt_q      <= 4'h0;
         o_sda_oe_n <= 1'b1;
      end else begin
         unique case (state_q)
            see_pkg::SEE_ST_IDLE: begin
               o_sda_oe_n <= 1'b1;
            end
            see_pkg::SEE_ST_SEL,
            see_pkg::SEE_ST_ADDR,
            see_pkg::SEE_ST_WDAT: begin
               if (scl_rise) begin
                  sh_q  <= {sh_q[6:0], sda_f};
                  cnt_q <= cnt_q + 4'h1;
               end else if (byte_end) begin
                  cnt_q <= 4'h0;
                  if (state_q == see_pkg::SEE_ST_SEL) begin
                     if (sel_ok) begin
                        o_sda_oe_n <= 1'b0;
                        state_q    <= see_pkg::SEE_ST_ACK;
                        if (sh_q[`SEE_SEL_RW_BIT]) begin
                           next_q <= see_pkg::SEE_ST_RDAT;
                        end else begin
                           next_q <= see_pkg::SEE_ST_ADDR;
                        end
                     end else begin
                        state_q <= see_pkg::SEE_ST_IDLE;
                     end
                  end else begin
                     // Address and data bytes are always acknowledged.
                     o_sda_oe_n <= 1'b0;
                     state_q    <= see_pkg::SEE_ST_ACK;
                     next_q     <= see_pkg::SEE_ST_WDAT;
                  end
               end
            end
            see_pkg::SEE_ST_ACK: begin
               if (ld_rd) begin
                  // Data changes only while the clock is low.
                  o_sda_oe_n <= rd_byte[7];
                  sh_q       <= {rd_byte[6:0], 1'b0};
                  cnt_q      <= 4'h1;
                  state_q    <= see_pkg::SEE_ST_RDAT;
               end else if (scl_fall) begin
                  o_sda_oe_n <= 1'b1;
                  cnt_q      <= 4'h0;
                  state_q    <= next_q;
               end
            end
            see_pkg::SEE_ST_RDAT: begin
               if (scl_fall) begin
                  if (cnt_q == `SEE_BYTE_BITS) begin
                     o_sda_oe_n <= 1'b1;
                     cnt_q      <= 4'h0;
                     mack_q     <= 1'b0;
                     state_q    <= see_pkg::SEE_ST_MACK;
                  end else begin
                     o_sda_oe_n <= sh_q[7];
                     sh_q       <= {sh_q[6:0], 1'b0};
                     cnt_q      <= cnt_q + 4'h1;
                  end
               end
            end
            see_pkg::SEE_ST_MACK: begin
               if (scl_rise) begin
                  mack_q <= ~sda_f;
               end else if (ld_rd) begin
                  o_sda_oe_n <= rd_byte[7];
                  sh_q       <= {rd_byte[6:0], 1'b0};
                  cnt_q      <= 4'h1;
                  state_q    <= see_pkg::SEE_ST_RDAT;
               end else if (scl_fall) begin
                  o_sda_oe_n <= 1'b1;
                  state_q    <= see_pkg::SEE_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Address counter: loaded by the address byte, stepped per data byte.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         addr_q <= '0;
      end else if (addr_load) begin
         addr_q <= sh_q[`SEE_ADDR_W-1:0];
      end else if (wr_byte) begin
         // Only the page bits step, so a long burst wraps in its row.
         addr_q[`SEE_PAGE_W-1:0] <= addr_q[`SEE_PAGE_W-1:0] + 3'h1;
      end else if (ld_rd) begin
         // Seven-bit counter rolls from the top location to zero.
         addr_q <= addr_q + 7'h01;
      end
   end

   // Page latch marks collect the slots of one write until its stop.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         pmask_q <= '0;
      end else if (ev_start | commit) begin
         // A write not closed by a stop programs nothing.
         pmask_q <= '0;
      end else if (wr_take) begin
         pmask_q[addr_q[`SEE_PAGE_W-1:0]] <= 1'b1;
      end
   end

   // One page latch per slot, filled by the byte aimed at that slot.
   for (genvar p = 0; p < `SEE_PAGE_BYTES; p++) begin : g_pbuf
      localparam logic [`SEE_PAGE_W-1:0] LP_S = `SEE_PAGE_W'(p);
      always_ff @(posedge i_mclk or posedge i_reset) begin
         if (i_reset) begin
            pbuf_q[p] <= `SEE_ERASED_BYTE;
         end else if (wr_take && (addr_q[`SEE_PAGE_W-1:0] == LP_S)) begin
            pbuf_q[p] <= sh_q;
         end
      end
   end

   // Self-timed program cycle; the bus is deaf while it runs.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         busy_q   <= 1'b0;
         wr_cnt_q <= '0;
      end else if (commit) begin
         busy_q   <= 1'b1;
         wr_cnt_q <= `SEE_WR_CNT_W'(P_WR_CYCLES - 1);
      end else if (busy_q) begin
         if (wr_cnt_q == '0) begin
            busy_q <= 1'b0;
         end else begin
            wr_cnt_q <= wr_cnt_q - `SEE_WR_CNT_W'(1);
         end
      end
   end

   // Memory array, one generate entry per location.
   for (genvar g = 0; g < `SEE_MEM_DEPTH; g++) begin : g_mem
      localparam logic [`SEE_ADDR_W-1:0] LP_A = `SEE_ADDR_W'(g);
      always_ff @(posedge i_mclk or posedge i_reset) begin
         if (i_reset) begin
            mem_q[g] <= `SEE_ERASED_BYTE;
         end else if (commit
                      && (row == LP_A[`SEE_ADDR_W-1:`SEE_PAGE_W])
                      && pmask_q[LP_A[`SEE_PAGE_W-1:0]]) begin
            mem_q[g] <= pbuf_q[LP_A[`SEE_PAGE_W-1:0]];
         end
      end
   end

   // The wire is open drain: only the low level is ever driven.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_sda_out <= 1'b0;
      end else begin
         o_sda_out <= 1'b0;
      end
   end

   assign o_busy = busy_q;

endmodule : see_eeprom_slave

// ### hdl/see_eeprom_map.svh
// Constants for the two-wire serial EEPROM slave: sizes, values, timing.
`ifndef SEE_EEPROM_MAP_SVH
`define SEE_EEPROM_MAP_SVH

// Array organisation.
`define SEE_ADDR_W        7
`define SEE_MEM_DEPTH     128
`define SEE_PAGE_BYTES    8
`define SEE_PAGE_W        3
`define SEE_ROW_W         4

// Content of a location as delivered.
`define SEE_ERASED_BYTE   8'hFF

// Bit count that closes one byte on the bus.
`define SEE_BYTE_BITS     4'h8

// Select byte field positions.
`define SEE_SEL_TYPE_HI   7
`define SEE_SEL_TYPE_LO   4
`define SEE_SEL_RW_BIT    0

// Idle level of the bus wires.
`define SEE_BUS_IDLE      1'b1

// Program cycle time and system clock period.
`define SEE_T_WR_NS       10000000
`define SEE_MCLK_NS       40
`define SEE_WR_CNT_W      18

`endif

// ### hdl/see_pkg.sv
// Types shared by the serial EEPROM slave design.
package see_pkg;

   typedef enum logic [6:0] {
      SEE_ST_IDLE = 7'h01,
      SEE_ST_SEL  = 7'h02,
      SEE_ST_ADDR = 7'h04,
      SEE_ST_WDAT = 7'h08,
      SEE_ST_ACK  = 7'h10,
      SEE_ST_RDAT = 7'h20,
      SEE_ST_MACK = 7'h40
   } see_state_t;

endpackage : see_pkg

// ### hdl/see_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
module see_pin_sync #(
   parameter logic P_RESET_LEVEL = 1'b1
) (
   input  wire logic i_mclk,
   input  wire logic i_reset,
   input  wire logic i_pin,
   output logic      o_level
);

   logic s1_q;
   logic s2_q;
   logic s3_q;

   // The first stage feeds only the second, so metastability stays there.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         s1_q <= P_RESET_LEVEL;
         s2_q <= P_RESET_LEVEL;
         s3_q <= P_RESET_LEVEL;
      end else begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change is taken once two settled stages agree.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) begin
         o_level <= P_RESET_LEVEL;
      end else if (s2_q == s3_q) begin
         o_level <= s3_q;
      end
   end

endmodule : see_pin_sync

// ### verif/see_eeprom_monitor.sv
// Concurrent checks on the pins of the serial EEPROM slave.
module see_eeprom_monitor #(
   parameter int unsigned P_WR_CYCLES = 20
) (
   input wire logic i_mclk,
   input wire logic i_reset,
   input wire logic i_scl,
   input wire logic i_sda_in,
   input wire logic i_write_protect_input,
   input wire logic o_sda_out,
   input wire logic o_sda_oe_n,
   input wire logic o_busy
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);
   int unsigned busy_len_q;
   // Counts how long each program cycle keeps the bus blocked.
   always_ff @(posedge i_mclk or posedge i_reset) begin
      if (i_reset) busy_len_q <= 0;
      else busy_len_q <= o_busy ? busy_len_q + 1 : 0;
   end
   AST_OPEN_DRAIN: assert property (o_sda_out == 1'h0)
      else $error("data output value is not low");
   AST_RESET_IDLE: assert property ($fell(i_reset) |-> o_sda_oe_n && !o_busy)
      else $error("not idle after reset");
   AST_SCL_HIGH_STABLE: assert property (i_scl && $past(i_scl) |-> $stable(o_sda_oe_n))
      else $error("data drive changed while clock high");
   AST_ACK_STANDS: assert property ($fell(o_sda_oe_n) |=> !o_sda_oe_n [*8])
      else $error("data drive released too early");
   AST_DRIVE_BOUNDED: assert property ($fell(o_sda_oe_n) |-> ##[1:300] o_sda_oe_n)
      else $error("data drive held too long");
   AST_BUSY_AFTER_STOP: assert property ($rose(o_busy) |-> i_scl && i_sda_in)
      else $error("program cycle began without a stop");
   AST_BUSY_QUIET: assert property (o_busy |-> o_sda_oe_n)
      else $error("device drove the bus while busy");
   AST_BUSY_LEN: assert property ($fell(o_busy) |->
      busy_len_q >= P_WR_CYCLES && busy_len_q <= P_WR_CYCLES + 1)
      else $error("program cycle length wrong");
   COV_BUSY: cover property ($rose(o_busy));
   COV_ACK: cover property ($fell(o_sda_oe_n));
   COV_POLL: cover property (o_busy && !i_scl);
endmodule : see_eeprom_monitor

bind see_eeprom_slave see_eeprom_monitor #(.P_WR_CYCLES(P_WR_CYCLES))
   u_see_eeprom_monitor (
   .i_mclk                (i_mclk),
   .i_reset               (i_reset),
   .i_scl                 (i_scl),
   .i_sda_in              (i_sda_in),
   .i_write_protect_input (i_write_protect_input),
   .o_sda_out             (o_sda_out),
   .o_sda_oe_n            (o_sda_oe_n),
   .o_busy                (o_busy)
);

// ### verif/see_bus_master.sv
// Behavioural two-wire bus master driving clock and data.
module see_bus_master (
   input  wire logic i_mclk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_scl = 1'h1;
      o_sda = 1'h1;
   end
   task automatic w(input int n);
      repeat (n) @(posedge i_mclk);
      #1;
   endtask : w
   // Data moves mid-way through the low phase so no false start is seen.
   task automatic bit_io(input logic b, output logic r);
      w(5);
      o_sda = b;
      w(5);
      o_scl = 1'h1;
      w(10);
      r = i_sda;
      o_scl = 1'h0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic m,
                       output logic [7:0] q, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q = {q[6:0], r};
      end
      bit_io(m, a);
   endtask : xfer
   task automatic start();
      w(5);
      o_sda = 1'h1;
      w(5);
      o_scl = 1'h1;
      w(10);
      o_sda = 1'h0;
      w(10);
      o_scl = 1'h0;
   endtask : start
   task automatic stop();
      w(5);
      o_sda = 1'h0;
      w(5);
      o_scl = 1'h1;
      w(10);
      o_sda = 1'h1;
      w(10);
   endtask : stop
endmodule : see_bus_master

// ### verif/tb_see_eeprom_slave.sv
// Self-checking bench for the serial EEPROM slave.
module tb_see_eeprom_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned WR_CYC  = 600;
   localparam logic [3:0]  TYPE_ID = 4'h5;
   logic        i_mclk = 1'h0;
   logic        i_reset = 1'h1;
   logic        wp = 1'h1;
   logic        scl, m_sda, sda, sda_out, sda_oe_n, busy, ack;
   logic [31:0] seed = 32'h88C8;
   logic [31:0] r;
   int          n_fail = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          mem [128];
   int          ptr = 0;
   int          a;
   always #20 i_mclk = ~i_mclk;
   // The wire has a pull-up, so a released line reads high.
   assign sda = m_sda & (sda_oe_n | sda_out);
   see_eeprom_slave #(.P_TYPE_ID(TYPE_ID), .P_WR_CYCLES(WR_CYC))
      u_see_eeprom_slave (
      .i_mclk                (i_mclk),
      .i_reset               (i_reset),
      .i_scl                 (scl),
      .i_sda_in              (sda),
      .i_write_protect_input (wp),
      .o_sda_out             (sda_out),
      .o_sda_oe_n            (sda_oe_n),
      .o_busy                (busy)
   );
   see_bus_master u_see_bus_master (
      .i_mclk (i_mclk),
      .i_sda  (sda),
      .o_scl  (scl),
      .o_sda  (m_sda)
   );
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   task automatic test_done();
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   always @(posedge i_mclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen,
                      input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic sel(input logic [7:0] b, output logic k);
      logic [7:0] q;
      u_see_bus_master.start();
      u_see_bus_master.xfer(b, 1'h1, q, k);
   endtask : sel
   task automatic go(input logic rw);
      logic [31:0] x;
      logic        k;
      x = rnd();
      sel({TYPE_ID, x[2:0], rw}, k);
      chk("select ack", {7'h00, k}, 8'h00);
   endtask : go
   task automatic put(input logic [7:0] d);
      logic [7:0] q;
      logic       k;
      u_see_bus_master.xfer(d, 1'h1, q, k);
      chk("byte ack", {7'h00, k}, 8'h00);
   endtask : put
   task automatic rread(input int ad, input int n);
      logic [7:0] q;
      logic       k;
      if (ad >= 0) begin
         go(1'h0);
         put(ad[7:0]);
         ptr = ad;
      end
      go(1'h1);
      for (int i = 0; i < n; i++) begin
         u_see_bus_master.xfer(8'hFF, i == n - 1, q, k);
         chk("read data", q, mem[ptr][7:0]);
         ptr = (ptr + 1) % 128;
      end
      u_see_bus_master.xfer(8'hFF, 1'h1, q, k);
      chk("after nack", {q[7:1], k}, 8'hFF);
      u_see_bus_master.stop();
   endtask : rread
   // Protected bytes still step the page slot, so the model steps it too.
   task automatic wr(input int ad, input int n, input logic p);
      logic [31:0] d;
      int          k;
      wp = p;
      go(1'h0);
      put(ad[7:0]);
      for (int i = 0; i < n; i++) begin
         d = rnd();
         put(d[7:0]);
         if (p) mem[(ad & 'h78) | ((ad + i) & 7)] = d[7:0];
      end
      u_see_bus_master.stop();
      if (p) chk("busy", {7'h00, busy}, 8'h01);
      for (k = 0; k < 40; k++) begin
         sel({TYPE_ID, 3'h0, 1'h0}, ack);
         if (ack === 1'h0) break;
      end
      u_see_bus_master.stop();
      chk("poll ack", {7'h00, ack}, 8'h00);
      if (p) chk("refused polls", {7'h00, k > 0}, 8'h01);
      wp = 1'h1;
   endtask : wr
   initial begin
      for (int i = 0; i < 128; i++) mem[i] = 'hFF;
      repeat (4) @(posedge i_mclk);
      #1;
      i_reset = 1'h0;
      chk("idle", {6'h00, busy, sda_oe_n}, 8'h01);
      r = rnd();
      rread(r & 127, 2);
      $display("test blank read done");
      for (int t = 0; t < 16; t++) begin
         r = rnd();
         sel({t[3:0], r[2:0], 1'h0}, ack);
         chk("type ack", {7'h00, ack}, {7'h00, t[3:0] != TYPE_ID});
         u_see_bus_master.stop();
      end
      $display("test type code done");
      r = rnd();
      a = r & 127;
      wr(a, 1, 1'h1);
      rread(a, 1);
      $display("test byte write done");
      a = (rnd() & 'h78) | 5;
      wr(a, 10, 1'h1);
      rread(a & 'h78, 8);
      $display("test page write done");
      wr(a, 3, 1'h0);
      rread(a & 'h78, 8);
      $display("test protect done");
      rread(125, 4);
      rread(-1, 2);
      $display("test wrap done");
      test_done();
   end
endmodule : tb_see_eeprom_slave
